// file: tsa_defs.svh
// Behaviour
// - not, and, or combine condition terms into one true or false result
// - compare a counter or flag against a constant with six relations
// - actions run only in the owning state when its condition is true
// - every action of a grouped list applies, not only the first; if both slots name one counter or flag, the second wins
// - increment adds one to the chosen counter
// - decrement subtracts one from the chosen counter
// - counter reset loads the configured initial value
// - set drives a flag to one, clear drives it to zero
// - final trigger stops capture and ends the run
// - segment close ends the current segment, capture moves to the next
// - with all segments full, the oldest segment is overwritten
// - segmented capture continues until the final trigger, then stops
// - segment close is ignored when the buffer is not segmented
// - storage begin raises the write gate, only in state storage mode
// - storage halt drops the write gate, only in state storage mode
// - a trigger with a quota captures exactly that many more samples
// - a trigger without a quota uses the default post-fill count
// - a new trigger cuts an open segment quota short, marked unfilled; the code starts no quota for that trigger and the old quota runs on
// - goto selects the named state as next state
// - branches of a state are checked in order, first true wins
// - all actions of a selected list act in the same cycle
// - up to twenty counters and flags with initial values and widths
`ifndef TSA_DEFS_SVH
`define TSA_DEFS_SVH
`define TSA_ADDR_W        8
`define TSA_A_CTRL        8'h00
`define TSA_A_STATUS      8'h04
`define TSA_A_COND        8'h08
`define TSA_A_DEFPF       8'h0C
`define TSA_A_SEGCFG      8'h10
`define TSA_A_CNTR_BASE   8'h20
`define TSA_A_PROG_BASE   8'h80
`define TSA_CTRL_ARM      0
`define TSA_CTRL_SQMODE   1
`define TSA_CTRL_SEGMODE  2
`define TSA_CTRL_ABORT    3
`define TSA_ST_RUN        0
`define TSA_ST_DONE       1
`define TSA_ST_GATE       2
`define TSA_ST_UNFILL     3
`define TSA_ST_FLAG_LSB   8
`define TSA_ST_STATE_LSB  24
`define TSA_ST_SEG_LSB    28
`define TSA_DEFPF_RST     16'h0010
`define TSA_OP_NONE       3'h0
`define TSA_OP_INC        3'h1
`define TSA_OP_DEC        3'h2
`define TSA_OP_RST        3'h3
`define TSA_OP_SET        3'h4
`define TSA_OP_CLR        3'h5
`define TSA_BUF_NONE      3'h0
`define TSA_BUF_TRIG      3'h1
`define TSA_BUF_SEG       3'h2
`define TSA_BUF_START     3'h3
`define TSA_BUF_STOP      3'h4
`endif

// file: tsa_pkg.sv
package tsa_pkg;
    // relational compare codes
    typedef enum logic [2:0] {
        TSA_GT = 3'h0, TSA_GE = 3'h1, TSA_EQ = 3'h2,
        TSA_NE = 3'h3, TSA_LE = 3'h4, TSA_LT = 3'h5
    } tsa_rel_t;
    // one branch slot: term masks, relation, actions
    typedef struct packed {
        logic        valid;
        logic [7:0]  cond_pos;
        logic [7:0]  cond_neg;
        logic        use_rel;
        logic        rel_is_flag;
        logic [4:0]  rel_sel;
        tsa_rel_t    rel_op;
        logic [15:0] rel_val;
        logic        combine_or;
        logic        invert;
        logic [2:0]  res_op_a;
        logic [4:0]  res_sel_a;
        logic [2:0]  res_op_b;
        logic [4:0]  res_sel_b;
        logic [2:0]  buf_op;
        logic [15:0] post_fill;
        logic        has_goto;
        logic [1:0]  goto_state;
    } tsa_branch_t;
    // lines to the acquisition buffer
    typedef struct packed {
        logic wr_en;
        logic seg_adv;
        logic done;
        logic unfilled;
    } tsa_buf_t;
    // sequencer run state
    typedef enum logic [2:0] {
        TSA_IDLE = 3'b001, TSA_RUN = 3'b010, TSA_END = 3'b100
    } tsa_run_t;
endpackage : tsa_pkg

// file: tsa_core.sv
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "tsa_defs.svh"
module tsa_core #(
    parameter int NCNT     = 20,
    parameter int NFLAG    = 20,
    parameter int CNT_W    = 16,
    parameter int NSTATE   = 4,
    parameter int NBR      = 2,
    parameter int NCOND    = 8,
    parameter int NSEG     = 4
) (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // wishbone slave
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [7:0]             adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic      [31:0]            dat_o,
    output logic                        ack_o,
    // probed trigger conditions
    input  wire logic [NCOND-1:0]       cond_i,
    // acquisition buffer side
    output tsa_pkg::tsa_buf_t           buf_o,
    output logic      [$clog2(NSEG)-1:0] seg_o
);
    localparam int NPROG = NSTATE * NBR;
    localparam int BRW   = $bits(tsa_pkg::tsa_branch_t);
    // slots are 16 bytes apart below the top of the map; the segment index must wrap cleanly
    if (NCNT > 20 || NFLAG > 20 || NCNT < 1 || NFLAG < 1 || CNT_W > 16 || CNT_W < 2
        || NSTATE != 4 || NCOND != 8 || (NSEG != 2 && NSEG != 4)
        || NBR < 1 || NPROG > 8) begin : g_bad_params
        $error("tsa_core: unsupported parameters");
    end

    // configuration and state
    logic [31:0]              ctrl_q;
    logic [15:0]              defpf_q;
    logic [CNT_W-1:0]         cnt_init_q [NCNT];
    logic [CNT_W-1:0]         cnt_q      [NCNT];
    logic [NFLAG-1:0]         flag_init_q;
    logic [NFLAG-1:0]         flag_q;
    logic [NFLAG-1:0]         flag_d;
    logic [CNT_W-1:0]         cnt_d      [NCNT];
    tsa_pkg::tsa_branch_t     prog_q     [NPROG];
    logic [1:0]               state_q;
    tsa_pkg::tsa_run_t        run_q;
    logic                     gate_q;
    logic                     pf_act_q;
    logic [15:0]              pf_cnt_q;
    logic                     pf_final_q;
    logic                     arm_pulse;
    logic                     wb_wr;
    logic [31:0]              rdata;

    // one branch evaluates: masked terms, relation, not and and/or
    function automatic logic br_true(input tsa_pkg::tsa_branch_t b,
                                     input logic [NCOND-1:0] c,
                                     input logic [15:0] lhs);
        logic t_and;
        logic t_or;
        logic rel;
        logic r;
        t_and = &((c & b.cond_pos) | (~c & b.cond_neg) | ~(b.cond_pos | b.cond_neg));
        t_or  = |((c & b.cond_pos) | (~c & b.cond_neg));
        unique case (b.rel_op)
            tsa_pkg::TSA_GT: rel = lhs >  b.rel_val;
            tsa_pkg::TSA_GE: rel = lhs >= b.rel_val;
            tsa_pkg::TSA_EQ: rel = lhs == b.rel_val;
            tsa_pkg::TSA_NE: rel = lhs != b.rel_val;
            tsa_pkg::TSA_LE: rel = lhs <= b.rel_val;
            tsa_pkg::TSA_LT: rel = lhs <  b.rel_val;
            default:         rel = 1'b0;
        endcase
        if (b.combine_or)
            r = t_or | (b.use_rel & rel);
        else
            r = t_and & (~b.use_rel | rel);
        return b.valid & (r ^ b.invert);
    endfunction : br_true

    // operand of a relation: counter value or flag, widened
    function automatic logic [15:0] rel_lhs(input tsa_pkg::tsa_branch_t b,
                                            input logic [15:0] cv,
                                            input logic fv);
        return b.rel_is_flag ? {15'h0000, fv} : cv;
    endfunction : rel_lhs

    // wishbone: single-cycle ack, dropped in the following cycle
    assign wb_wr = cyc_i & stb_i & we_i & ~ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i & stb_i & ~ack_o;
    end

    // control and default post-fill registers
    assign arm_pulse = wb_wr && adr_i == `TSA_A_CTRL && sel_i[0] && dat_i[`TSA_CTRL_ARM];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q  <= 32'h0000_0000;
            defpf_q <= `TSA_DEFPF_RST;
        end else if (wb_wr) begin
            if (adr_i == `TSA_A_CTRL && sel_i[0])
                ctrl_q[7:0] <= {dat_i[7:1], 1'b0}; // arm reads back as zero
            if (adr_i == `TSA_A_DEFPF && sel_i[0])
                defpf_q[7:0] <= dat_i[7:0];
            if (adr_i == `TSA_A_DEFPF && sel_i[1])
                defpf_q[15:8] <= dat_i[15:8];
        end
    end

    // initial values of counters and flags; flags init word at segcfg
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_init_q <= '0;
            for (int i = 0; i < NCNT; i++)
                cnt_init_q[i] <= '0;
        end else if (wb_wr) begin
            if (adr_i == `TSA_A_SEGCFG)
                flag_init_q <= dat_i[NFLAG-1:0];
            for (int i = 0; i < NCNT; i++)
                if (adr_i == `TSA_A_CNTR_BASE + 8'(i*4) && sel_i[1:0] == 2'h3)
                    cnt_init_q[i] <= dat_i[CNT_W-1:0];
        end
    end

    // program slots: 16-byte stride, three words used, top bits first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NPROG; i++)
                prog_q[i] <= '0;
        end else if (wb_wr && adr_i >= `TSA_A_PROG_BASE && run_q != tsa_pkg::TSA_RUN) begin
            for (int i = 0; i < NPROG; i++) begin
                if (adr_i[7:4] == 4'(8 + i)) begin
                    if (adr_i[3:2] == 2'h0)
                        prog_q[i][BRW-1 -: 32] <= dat_i;
                    else if (adr_i[3:2] == 2'h1)
                        prog_q[i][BRW-33 -: 32] <= dat_i;
                    else if (adr_i[3:2] == 2'h2)
                        prog_q[i][BRW-65:0] <= dat_i[BRW-65:0];
                end
            end
        end
    end

    // branch selection in the current state, first true wins
    tsa_pkg::tsa_branch_t act;
    logic                 fire;
    always_comb begin
        act  = '0;
        fire = 1'b0;
        for (int k = NBR - 1; k >= 0; k--) begin
            if (br_true(prog_q[int'(state_q) * NBR + k], cond_i,
                        rel_lhs(prog_q[int'(state_q) * NBR + k],
                                16'(cnt_q[prog_q[int'(state_q) * NBR + k].rel_sel
                                          % 5'(NCNT)]),
                                flag_q[prog_q[int'(state_q) * NBR + k].rel_sel
                                       % 5'(NFLAG)]))) begin
                act  = prog_q[int'(state_q) * NBR + k];
                fire = run_q == tsa_pkg::TSA_RUN;
            end
        end
    end

    // apply one resource action to a counter/flag image
    function automatic logic [CNT_W:0] res_apply(input logic [2:0] op,
                                                 input logic [CNT_W-1:0] c,
                                                 input logic [CNT_W-1:0] ci,
                                                 input logic f);
        logic [CNT_W-1:0] cn;
        logic             fn;
        cn = c;
        fn = f;
        unique case (op)
            `TSA_OP_INC: cn = c + 1'b1;
            `TSA_OP_DEC: cn = c - 1'b1;
            `TSA_OP_RST: cn = ci;
            `TSA_OP_SET: fn = 1'b1;
            `TSA_OP_CLR: fn = 1'b0;
            default: ;
        endcase
        return {fn, cn};
    endfunction : res_apply

    // both resource slots of the list act on the same pre-edge values
    always_comb begin
        flag_d = flag_q;
        for (int i = 0; i < NCNT; i++)
            cnt_d[i] = cnt_q[i];
        for (int i = 0; i < NCNT; i++) begin
            if (fire && act.res_sel_a == 5'(i) && act.res_op_a != `TSA_OP_NONE
                && act.res_op_a <= `TSA_OP_RST)
                cnt_d[i] = CNT_W'(res_apply(act.res_op_a, cnt_q[i], cnt_init_q[i], 1'b0));
            if (fire && act.res_sel_b == 5'(i) && act.res_op_b != `TSA_OP_NONE
                && act.res_op_b <= `TSA_OP_RST)
                cnt_d[i] = CNT_W'(res_apply(act.res_op_b, cnt_q[i], cnt_init_q[i], 1'b0));
        end
        for (int i = 0; i < NFLAG; i++) begin
            if (fire && act.res_sel_a == 5'(i) && act.res_op_a >= `TSA_OP_SET)
                flag_d[i] = 1'(res_apply(act.res_op_a, '0, '0, flag_q[i]) >> CNT_W);
            if (fire && act.res_sel_b == 5'(i) && act.res_op_b >= `TSA_OP_SET)
                flag_d[i] = 1'(res_apply(act.res_op_b, '0, '0, flag_q[i]) >> CNT_W);
        end
    end

    // counters and flags: arm loads initial values, run applies actions
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= '0;
            for (int i = 0; i < NCNT; i++)
                cnt_q[i] <= '0;
        end else if (arm_pulse) begin
            flag_q <= flag_init_q;
            for (int i = 0; i < NCNT; i++)
                cnt_q[i] <= cnt_init_q[i];
        end else begin
            flag_q <= flag_d;
            for (int i = 0; i < NCNT; i++)
                cnt_q[i] <= cnt_d[i];
        end
    end

    // sequencer state: goto only when named, otherwise hold
    always_ff @(posedge clk_i) begin
        if (rst_i || arm_pulse)
            state_q <= 2'h0;
        else if (fire && act.has_goto)
            state_q <= act.goto_state;
    end

    // buffer control decode for this cycle
    logic trig_now;
    logic seg_now;
    logic sq_mode;
    assign sq_mode  = ctrl_q[`TSA_CTRL_SQMODE];
    assign trig_now = fire && act.buf_op == `TSA_BUF_TRIG;
    assign seg_now  = fire && act.buf_op == `TSA_BUF_SEG
                      && ctrl_q[`TSA_CTRL_SEGMODE];

    // write gate: free running unless state storage mode is chosen
    always_ff @(posedge clk_i) begin
        if (rst_i)
            gate_q <= 1'b0;
        else if (arm_pulse)
            gate_q <= ~dat_i[`TSA_CTRL_SQMODE]; // mode bit of this same write
        else if (run_q != tsa_pkg::TSA_RUN)
            gate_q <= 1'b0;
        else if (fire && sq_mode && act.buf_op == `TSA_BUF_START)
            gate_q <= 1'b1;
        else if (fire && sq_mode && act.buf_op == `TSA_BUF_STOP)
            gate_q <= 1'b0;
        else if (pf_act_q && pf_cnt_q == 16'h0001 && gate_q && pf_final_q)
            gate_q <= 1'b0;
    end

    // post-fill quota counts written samples after a trigger
    always_ff @(posedge clk_i) begin
        if (rst_i || arm_pulse) begin
            pf_act_q   <= 1'b0;
            pf_cnt_q   <= 16'h0000;
            pf_final_q <= 1'b0;
        end else if ((trig_now || seg_now) && !(pf_act_q && !pf_final_q && trig_now)) begin
            pf_act_q   <= 1'b1;
            pf_final_q <= trig_now;
            pf_cnt_q   <= act.post_fill != 16'h0000 ? act.post_fill : defpf_q;
        end else if (pf_act_q && !pf_final_q && seg_now) begin
            pf_cnt_q <= act.post_fill != 16'h0000 ? act.post_fill : defpf_q;
        end else if (pf_act_q && gate_q) begin
            pf_cnt_q <= pf_cnt_q - 16'h0001;
            if (pf_cnt_q == 16'h0001)
                pf_act_q <= 1'b0;
        end
    end

    // run state, segment index and buffer strobes
    logic seg_close;
    assign seg_close = pf_act_q && !pf_final_q && gate_q && pf_cnt_q == 16'h0001;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q  <= tsa_pkg::TSA_IDLE;
            seg_o  <= '0;
            buf_o  <= '0;
        end else begin
            buf_o.wr_en   <= gate_q && run_q == tsa_pkg::TSA_RUN;
            buf_o.seg_adv <= 1'b0;
            unique case (run_q)
                tsa_pkg::TSA_IDLE: begin
                    if (arm_pulse) begin
                        run_q          <= tsa_pkg::TSA_RUN;
                        seg_o          <= '0;
                        buf_o.done     <= 1'b0;
                        buf_o.unfilled <= 1'b0;
                    end
                end
                tsa_pkg::TSA_RUN: begin
                    if (ctrl_q[`TSA_CTRL_ABORT] ||
                        (pf_act_q && pf_final_q && gate_q && pf_cnt_q == 16'h0001)) begin
                        run_q      <= tsa_pkg::TSA_END;
                        buf_o.done <= 1'b1;
                        buf_o.wr_en <= 1'b0; // no write in the cycle that shows done
                    end else if (pf_act_q && !pf_final_q && (trig_now || seg_now)) begin
                        buf_o.unfilled <= 1'b1;
                        buf_o.seg_adv  <= 1'b1;
                        seg_o          <= seg_o + 1'b1;
                    end else if (seg_close) begin
                        buf_o.seg_adv <= 1'b1;
                        seg_o         <= seg_o + 1'b1; // wraps onto oldest
                    end
                end
                tsa_pkg::TSA_END: begin
                    if (arm_pulse) begin
                        run_q          <= tsa_pkg::TSA_RUN;
                        seg_o          <= '0;
                        buf_o.done     <= 1'b0;
                        buf_o.unfilled <= 1'b0;
                    end
                end
                default: run_q <= tsa_pkg::TSA_IDLE;
            endcase
        end
    end

    // read mux
    always_comb begin
        rdata = 32'h0000_0000;
        if (adr_i == `TSA_A_CTRL)
            rdata = ctrl_q;
        else if (adr_i == `TSA_A_STATUS) begin
            rdata[`TSA_ST_RUN]    = run_q == tsa_pkg::TSA_RUN;
            rdata[`TSA_ST_DONE]   = buf_o.done;
            rdata[`TSA_ST_GATE]   = gate_q;
            rdata[`TSA_ST_UNFILL] = buf_o.unfilled;
            rdata[`TSA_ST_FLAG_LSB +: 16] = 16'(flag_q);
            rdata[`TSA_ST_STATE_LSB +: 2] = state_q;
            rdata[`TSA_ST_SEG_LSB +: 2]   = 2'(seg_o);
        end else if (adr_i == `TSA_A_COND)
            rdata = 32'(cond_i);
        else if (adr_i == `TSA_A_DEFPF)
            rdata = {16'h0000, defpf_q};
        else if (adr_i == `TSA_A_SEGCFG)
            rdata = 32'(flag_init_q);
        else begin
            for (int i = 0; i < NCNT; i++)
                if (adr_i == `TSA_A_CNTR_BASE + 8'(i*4))
                    rdata = {16'(cnt_q[i]), 16'(cnt_init_q[i])};
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else
            dat_o <= rdata;
    end
endmodule : tsa_core
`default_nettype wire

// file: tsa_core_props.sv
`timescale 1ns/1ns
`default_nettype none
module tsa_core_props #(
    parameter int NCOND = 8,
    parameter int NSEG  = 4
) (
    // clock and reset
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    // register bus
    input wire logic                    cyc_i,
    input wire logic                    stb_i,
    input wire logic                    we_i,
    input wire logic [7:0]              adr_i,
    input wire logic [3:0]              sel_i,
    input wire logic [31:0]             dat_i,
    input wire logic [31:0]             dat_o,
    input wire logic                    ack_o,
    // probes and buffer side
    input wire logic [NCOND-1:0]        cond_i,
    input wire tsa_pkg::tsa_buf_t       buf_o,
    input wire logic [$clog2(NSEG)-1:0] seg_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // a taken request is answered by exactly one ack pulse
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence ans_s;
        ack_o ##1 !ack_o;
    endsequence

    bus_ack_a: assert property (req_s |=> ans_s)
        else $error("bus request not answered by one ack pulse");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    seg_step_a: assert property (buf_o.seg_adv |-> seg_o == $past(seg_o) + 1'b1)
        else $error("segment index did not step with advance");
    seg_pulse_a: assert property (buf_o.seg_adv |=> !buf_o.seg_adv)
        else $error("segment advance longer than one cycle");
    done_gate_a: assert property (buf_o.done |-> !buf_o.wr_en)
        else $error("buffer written after the run ended");
    done_hold_a: assert property (buf_o.done && !(cyc_i && stb_i && we_i) |=> buf_o.done)
        else $error("run end flag dropped without a bus write");
    cut_mark_a: assert property ($rose(buf_o.unfilled) |-> buf_o.seg_adv)
        else $error("unfilled mark without a segment cut");
    reset_clear_a: assert property ($fell(rst_i) |-> buf_o == '0 && seg_o == '0)
        else $error("buffer lines not clear after reset");
endmodule : tsa_core_props
`default_nettype wire

// file: tsa_acq_model.sv
`timescale 1ns/1ns
`default_nettype none
module tsa_acq_model (
    // clock and reset
    input wire logic              clk_i,
    input wire logic              rst_i,
    // lines from the sequencer
    input wire tsa_pkg::tsa_buf_t buf_i,
    input wire logic [1:0]        seg_i,
    // sample and segment tallies
    output logic      [15:0]      wr_cnt_o,
    output logic      [15:0]      adv_cnt_o
);
    // count stored samples and closed segments; the slot index simply wraps,
    // so a full ring reuses its oldest segment
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_cnt_o  <= 16'h0000;
            adv_cnt_o <= 16'h0000;
        end else begin
            if (buf_i.wr_en) wr_cnt_o <= wr_cnt_o + 16'h0001;
            if (buf_i.seg_adv) adv_cnt_o <= adv_cnt_o + 16'h0001;
        end
    end
endmodule : tsa_acq_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tsa_defs.svh"
module tb;
    logic              clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [7:0]        adr_i, cond_i, c;
    logic [3:0]        sel_i;
    logic [31:0]       dat_i, dat_o, rd;
    tsa_pkg::tsa_buf_t buf_o;
    logic [1:0]        seg_o;
    logic [15:0]       wr_cnt, adv_cnt, adv0, exp_cnt, dpf, n;
    tsa_pkg::tsa_branch_t br;
    int                mismatches, total_checks, cycles;

    tsa_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .cond_i(cond_i), .buf_o(buf_o), .seg_o(seg_o));
    tsa_acq_model u_acq (.clk_i(clk_i), .rst_i(rst_i), .buf_i(buf_o), .seg_i(seg_o),
        .wr_cnt_o(wr_cnt), .adv_cnt_o(adv_cnt));

    // clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: count %h expected %h", $time, got, exp);
        end
    endtask : chk_cnt

    // one classic cycle; the request stands until ack is seen at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1); // a hang ends at the cycle ceiling
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : wb

    function automatic tsa_pkg::tsa_branch_t mk(input logic [7:0] pos, input logic [7:0] neg,
        input logic [2:0] op, input logic [4:0] sel, input logic [2:0] bop,
        input logic [15:0] pf, input logic go, input logic [1:0] gs);
        tsa_pkg::tsa_branch_t b;
        b = '0;
        b.valid = 1'b1;
        b.cond_pos = pos;
        b.cond_neg = neg;
        b.res_op_b = op;
        b.res_sel_b = sel;
        b.buf_op = bop;
        b.post_fill = pf;
        b.has_goto = go;
        b.goto_state = gs;
        return b;
    endfunction : mk

    // a slot is three words at a 16-byte stride, top bits first
    task automatic prog(input int s, input int bi, input tsa_pkg::tsa_branch_t b);
        logic [7:0] a;
        a = `TSA_A_PROG_BASE + 8'(32 * s + 16 * bi);
        wb(1'b1, a, b[82:51]);
        wb(1'b1, a + 8'h04, b[50:19]);
        wb(1'b1, a + 8'h08, 32'(b[18:0]));
    endtask : prog

    task automatic pulse(input logic [7:0] v, input int gap);
        @(posedge clk_i);
        cond_i <= v;
        @(posedge clk_i);
        cond_i <= 8'h00;
        repeat (gap) @(posedge clk_i);
    endtask : pulse

    // stored samples until the run ends
    task automatic count_wr(output logic [15:0] cnt);
        cnt = 16'h0000;
        repeat (300) begin
            @(posedge clk_i);
            if (buf_o.done === 1'b1) break;
            if (buf_o.wr_en === 1'b1) cnt++;
        end
    endtask : count_wr

    initial begin
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, cond_i} = '0;
        sel_i = 4'hF;
        rst_i = 1'b1;
        {mismatches, total_checks, cycles} = '0;
        void'($urandom(96526));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `TSA_A_STATUS, 32'h0);
        chk_reg(rd, 32'h0);
        wb(1'b0, `TSA_A_DEFPF, 32'h0);
        chk_reg(rd, 32'(`TSA_DEFPF_RST));
        wb(1'b0, 8'h14, 32'h0);
        chk_reg(rd, 32'h0);
        // random counting with a negated term and branch priority
        exp_cnt = 16'(40 + $urandom_range(0, 100));
        wb(1'b1, `TSA_A_CNTR_BASE, 32'(exp_cnt));
        prog(0, 0, mk(8'h01, 8'h04, `TSA_OP_INC, 5'd0, `TSA_BUF_NONE, 16'h0, 1'b0, 2'd0));
        br = mk(8'h02, 8'h00, `TSA_OP_DEC, 5'd0, `TSA_BUF_NONE, 16'h0, 1'b0, 2'd0);
        br.use_rel = 1'b1; // decrement only at or above the floor
        br.rel_op = tsa_pkg::TSA_GE;
        br.rel_val = 16'd90;
        prog(0, 1, br);
        wb(1'b1, `TSA_A_CTRL, 32'h1);
        repeat (60) begin
            @(posedge clk_i);
            c = 8'($urandom()) & 8'h07;
            cond_i <= c;
            if (c[0] && !c[2]) exp_cnt++;
            else if (c[1] && exp_cnt >= 16'd90) exp_cnt--;
        end
        pulse(8'h00, 3);
        wb(1'b1, `TSA_A_CTRL, 32'h8);
        wb(1'b0, `TSA_A_CNTR_BASE, 32'h0);
        chk_cnt(rd[31:16], exp_cnt);
        // flag set with goto, then a trigger on the default quota
        dpf = 16'($urandom_range(2, 9));
        wb(1'b1, `TSA_A_DEFPF, 32'(dpf));
        prog(0, 0, mk(8'h08, 8'h00, `TSA_OP_SET, 5'd1, `TSA_BUF_NONE, 16'h0, 1'b1, 2'd1));
        prog(0, 1, '0);
        prog(1, 0, mk(8'h10, 8'h00, `TSA_OP_NONE, 5'd0, `TSA_BUF_TRIG, 16'h0, 1'b0, 2'd0));
        prog(1, 1, '0);
        wb(1'b1, `TSA_A_CTRL, 32'h1);
        pulse(8'h10, 2);
        wb(1'b0, `TSA_A_STATUS, 32'h0);
        chk_reg(rd & 32'h0300_0003, 32'h0000_0001);
        pulse(8'h08, 2);
        wb(1'b0, `TSA_A_STATUS, 32'h0);
        chk_reg(rd & 32'h0300_0203, 32'h0100_0201);
        pulse(8'h10, 0);
        count_wr(n);
        chk_cnt(n, dpf);
        wb(1'b0, `TSA_A_STATUS, 32'h0);
        chk_reg(rd & 32'h3, 32'h2);
        // segments: a cut quota, ring wrap, then a final quota
        prog(0, 0, mk(8'h40, 8'h00, `TSA_OP_NONE, 5'd0, `TSA_BUF_SEG, 16'd4, 1'b0, 2'd0));
        prog(0, 1, mk(8'h80, 8'h00, `TSA_OP_NONE, 5'd0, `TSA_BUF_TRIG, 16'd3, 1'b0, 2'd0));
        adv0 = adv_cnt;
        wb(1'b1, `TSA_A_CTRL, 32'h5);
        pulse(8'h40, 0);
        repeat (4) pulse(8'h40, 10);
        pulse(8'h80, 0);
        count_wr(n);
        chk_cnt(n, 16'd3);
        chk_cnt(adv_cnt - adv0, 16'd5);
        chk_reg(32'(seg_o), 32'h1);
        wb(1'b0, `TSA_A_STATUS, 32'h0);
        chk_reg(rd & 32'hB, 32'hA);
        // storage qualifier gate
        prog(0, 0, mk(8'h01, 8'h00, `TSA_OP_NONE, 5'd0, `TSA_BUF_START, 16'h0, 1'b0, 2'd0));
        prog(0, 1, mk(8'h02, 8'h00, `TSA_OP_NONE, 5'd0, `TSA_BUF_STOP, 16'h0, 1'b0, 2'd0));
        wb(1'b1, `TSA_A_CTRL, 32'h3);
        pulse(8'h00, 2);
        chk_reg(32'(buf_o.wr_en), 32'h0);
        pulse(8'h01, 2);
        chk_reg(32'(buf_o.wr_en), 32'h1);
        pulse(8'h02, 2);
        chk_reg(32'(buf_o.wr_en), 32'h0);
        wb(1'b1, `TSA_A_CTRL, 32'h8);
        stop_test();
    end
endmodule : tb

bind tsa_core tsa_core_props #(.NCOND(NCOND), .NSEG(NSEG)) u_props (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cond_i(cond_i), .buf_o(buf_o), .seg_o(seg_o));
`default_nettype wire
